//--- include/cfg_word_pkg.sv
/*
  Constants and types for the device configuration word.
  Assumes one 25 MHz clock and a 14-bit non-volatile configuration word.
*/
package cfg_word_pkg;

  localparam int WORD_W = 14;
  localparam logic [13:0] CFG_ADDR = 14'h2007;
  localparam logic [13:0] IMPL_MASK = 14'h31ff;
  localparam logic [13:0] BLANK_WORD = 14'h31ff;

  localparam int TRIM_HI = 13;
  localparam int TRIM_LO = 12;
  localparam int DATA_PROT_BIT = 8;
  localparam int PROG_PROT_BIT = 7;
  localparam int BROWN_EN_BIT = 6;
  localparam int EXT_RESET_BIT = 5;
  localparam int PWRUP_EN_BIT = 4;
  localparam int WATCHDOG_BIT = 3;
  localparam int OSC_HI = 2;
  localparam int OSC_LO = 0;

  localparam int PWRUP_TIME_US = 72000;
  localparam int CLK_MHZ = 25;
  localparam int PWRUP_CYCLES = PWRUP_TIME_US * CLK_MHZ;
  localparam int CNT_W = 21;
  localparam int DIV_W = 2;
  localparam int DIV_MSB = 1;

  typedef enum logic [2:0] {
    OSC_LOW_POWER_CRYSTAL = 3'h0,
    OSC_STANDARD_CRYSTAL = 3'h1,
    OSC_HIGH_SPEED_CRYSTAL = 3'h2,
    OSC_EXTERNAL_CLOCK = 3'h3,
    OSC_INTERNAL_IO = 3'h4,
    OSC_INTERNAL_DIVOUT = 3'h5,
    OSC_RESCAP_IO = 3'h6,
    OSC_RESCAP_DIVOUT = 3'h7
  } osc_mode_type;

  typedef enum logic [2:0] {
    SEQ_PWRUP = 3'h0,
    SEQ_OSC_WAIT = 3'h1,
    SEQ_RUN = 3'h2,
    SEQ_SLEEP = 3'h3,
    SEQ_BROWN = 3'h4
  } seq_state_type;

  typedef struct packed {
    logic [1:0] bandgap_trim;
    logic data_protect_n;
    logic program_protect_n;
    logic brownout_detect_enable;
    logic ext_reset_pin_select;
    logic powerup_delay_enable_n;
    logic watchdog_enable_bit;
    osc_mode_type osc_select;
    logic divided_clock_output;
    logic osc_pin_two_io;
    logic osc_pin_one_io;
    logic crystal_mode;
    logic internal_clock;
    logic shared_pin_io;
  } cfg_type;

  typedef struct packed {
    logic prog_mode;
    logic prog_write;
    logic [13:0] prog_addr;
    logic [13:0] prog_wdata;
    logic reset_pin_n;
    logic brownout;
    logic xtal_ready;
    logic watchdog_timeout;
    logic int_req;
  } pin_type;

endpackage : cfg_word_pkg

//--- hw/device_config_word_decoder.sv
/*
  Configuration word store, decoder and reset/wake sequencer.
  Assumes pins arrive asynchronously, SLEEP_REQ comes from core logic on CLK,
  and RST is the power-on reset of the device.
*/
`timescale 1ns/1ps

// Operation
// - Programmed bit reads zero, blank bit reads one; fields decoded with that polarity.
// - Word sits at configuration address, reachable only in programming mode.
// - Word is 14 bits; bits 11 to 9 always read zero.
// - Bits 13:12 trim bandgap, 00 lowest, 11 highest voltage.
// - Bit 8 one leaves data memory open, zero protects it.
// - Turning data protection off erases all data memory.
// - Bit 7 one leaves program memory open, zero protects it.
// - Turning program protection off erases program memory and oscillator trim.
// - Bit 6 one enables brown-out detection, zero disables it.
// - Brown-out enable never turns on the power-up delay by itself.
// - Bit 5 one makes shared pin the external reset; zero makes it I/O.
// - External reset in internal or resistor-capacitor mode stops the oscillator.
// - Bit 4 zero enables the power-up delay, one disables it.
// - Power-up delay holds reset 72 ms, only after power-on.
// - Brown-out gives a reset of at least 72 ms.
// - Start-up wait holds reset until the crystal is stable.
// - Bit 3 enables the watchdog, which runs from its own oscillator.
// - Codes 111 to 011 select resistor-capacitor, internal and external clock modes.
// - Codes 010, 001, 000 select the three crystal modes on both pins.
// - Sleep ends on external reset, watchdog wake-up or interrupt.
// - Divided-output modes drive oscillator frequency over four on the clock pin.
module device_config_word_decoder #(
  parameter int PWRUP_CYCLES = cfg_word_pkg::PWRUP_CYCLES,
  parameter logic [13:0] BLANK_WORD = cfg_word_pkg::BLANK_WORD
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Programming port
  input wire logic PROG_MODE,
  input wire logic PROG_WRITE,
  input wire logic [13:0] PROG_ADDR,
  input wire logic [13:0] PROG_WDATA,
  output logic [13:0] PROG_RDATA,
  output logic DATA_ERASE,
  output logic PROG_ERASE,
  // Reset and wake sources
  input wire logic RESET_PIN_N,
  input wire logic BROWNOUT,
  input wire logic XTAL_READY,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic INT_REQ,
  input wire logic SLEEP_REQ,
  // Decoded configuration
  output cfg_word_pkg::cfg_type CFG,
  // Clock and reset control
  output logic CORE_RESET,
  output logic OSC_RUN,
  output logic ASLEEP,
  output logic WAKE,
  output logic DIVIDED_CLOCK_OUTPUT_PIN,
  output logic DIVIDED_CLOCK_OUTPUT_OE
);

  // Field decode; programmed bits read zero, so raw bit polarity is kept
  function automatic cfg_word_pkg::cfg_type decode_word(input logic [13:0] w);
    cfg_word_pkg::cfg_type c;
    c.bandgap_trim = w[cfg_word_pkg::TRIM_HI:cfg_word_pkg::TRIM_LO];
    c.data_protect_n = w[cfg_word_pkg::DATA_PROT_BIT];
    c.program_protect_n = w[cfg_word_pkg::PROG_PROT_BIT];
    c.brownout_detect_enable = w[cfg_word_pkg::BROWN_EN_BIT];
    c.ext_reset_pin_select = w[cfg_word_pkg::EXT_RESET_BIT];
    c.powerup_delay_enable_n = w[cfg_word_pkg::PWRUP_EN_BIT];
    c.watchdog_enable_bit = w[cfg_word_pkg::WATCHDOG_BIT];
    c.osc_select = cfg_word_pkg::osc_mode_type'(w[cfg_word_pkg::OSC_HI:cfg_word_pkg::OSC_LO]);
    c.divided_clock_output = (c.osc_select == cfg_word_pkg::OSC_INTERNAL_DIVOUT) ||
      (c.osc_select == cfg_word_pkg::OSC_RESCAP_DIVOUT);
    c.osc_pin_two_io = (c.osc_select == cfg_word_pkg::OSC_INTERNAL_IO) ||
      (c.osc_select == cfg_word_pkg::OSC_RESCAP_IO) || (c.osc_select == cfg_word_pkg::OSC_EXTERNAL_CLOCK);
    c.osc_pin_one_io = (c.osc_select == cfg_word_pkg::OSC_INTERNAL_IO) ||
      (c.osc_select == cfg_word_pkg::OSC_INTERNAL_DIVOUT);
    c.crystal_mode = (c.osc_select <= cfg_word_pkg::OSC_HIGH_SPEED_CRYSTAL);
    c.internal_clock = w[cfg_word_pkg::OSC_HI];
    c.shared_pin_io = !w[cfg_word_pkg::EXT_RESET_BIT];
    return c;
  endfunction : decode_word

  typedef struct packed {
    cfg_word_pkg::pin_type sync1;
    cfg_word_pkg::pin_type sync2;
    logic write_prev;
    logic [13:0] nv;
    cfg_word_pkg::cfg_type cfg;
    cfg_word_pkg::seq_state_type seq;
    logic [cfg_word_pkg::CNT_W-1:0] cnt;
    logic [cfg_word_pkg::DIV_W-1:0] div;
    logic [13:0] rdata;
    logic data_erase;
    logic prog_erase;
    logic wake;
  } state_type;

  localparam cfg_word_pkg::pin_type PIN_IDLE = '{reset_pin_n: 1'b1, default: '0};
  localparam cfg_word_pkg::cfg_type BLANK_CFG = decode_word(BLANK_WORD);
  localparam logic [cfg_word_pkg::CNT_W-1:0] CNT_LOAD = cfg_word_pkg::CNT_W'(PWRUP_CYCLES - 1);

  // Power-on start: delay only when the blank word enables it
  localparam cfg_word_pkg::seq_state_type SEQ_START = BLANK_CFG.powerup_delay_enable_n ?
    cfg_word_pkg::SEQ_OSC_WAIT : cfg_word_pkg::SEQ_PWRUP;

  localparam state_type STATE_RESET = '{
    sync1: PIN_IDLE,
    sync2: PIN_IDLE,
    write_prev: 1'b0,
    nv: BLANK_WORD & cfg_word_pkg::IMPL_MASK,
    cfg: BLANK_CFG,
    seq: SEQ_START,
    cnt: CNT_LOAD,
    div: '0,
    rdata: '0,
    data_erase: 1'b0,
    prog_erase: 1'b0,
    wake: 1'b0
  };

  // Parameter checks
  if (PWRUP_CYCLES < 1 || PWRUP_CYCLES >= (1 << cfg_word_pkg::CNT_W))
  begin : g_bad_pwrup
    $error("PWRUP_CYCLES out of counter range");
  end

  state_type state_ff;
  state_type nxt_state;
  cfg_word_pkg::pin_type pins_in;
  logic access_ok;
  logic write_hit;
  logic [13:0] new_word;
  logic ext_reset_active;
  logic brownout_active;
  logic watchdog_event;
  logic core_reset;

  // Pin group for the synchroniser
  assign pins_in = '{
    prog_mode: PROG_MODE,
    prog_write: PROG_WRITE,
    prog_addr: PROG_ADDR,
    prog_wdata: PROG_WDATA,
    reset_pin_n: RESET_PIN_N,
    brownout: BROWNOUT,
    xtal_ready: XTAL_READY,
    watchdog_timeout: WATCHDOG_TIMEOUT,
    int_req: INT_REQ
  };

  // Word reachable only at its address in programming mode
  assign access_ok = state_ff.sync2.prog_mode &&
    (state_ff.sync2.prog_addr == cfg_word_pkg::CFG_ADDR);

  // Rising edge of the write strobe
  assign write_hit = access_ok && state_ff.sync2.prog_write && !state_ff.write_prev;

  // Unimplemented bits stored and read as zero
  assign new_word = state_ff.sync2.prog_wdata & cfg_word_pkg::IMPL_MASK;

  // Shared pin is reset input only when selected, active low
  assign ext_reset_active = state_ff.cfg.ext_reset_pin_select &&
    !state_ff.sync2.reset_pin_n;

  assign brownout_active = state_ff.cfg.brownout_detect_enable &&
    state_ff.sync2.brownout;

  // Watchdog timeout counts only when enabled
  assign watchdog_event = state_ff.cfg.watchdog_enable_bit &&
    state_ff.sync2.watchdog_timeout;

  // Core held in reset outside run and sleep
  assign core_reset = ext_reset_active || state_ff.sync2.prog_mode ||
    ((state_ff.seq != cfg_word_pkg::SEQ_RUN) &&
    (state_ff.seq != cfg_word_pkg::SEQ_SLEEP));

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.sync1 = pins_in;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.write_prev = state_ff.sync2.prog_write;
    nxt_state.data_erase = 1'b0;
    nxt_state.prog_erase = 1'b0;
    nxt_state.wake = 1'b0;
    nxt_state.div = state_ff.div + cfg_word_pkg::DIV_W'(1);

    // Programmer write and erase side effects
    if (write_hit)
    begin
      nxt_state.nv = new_word;
      nxt_state.data_erase = !state_ff.nv[cfg_word_pkg::DATA_PROT_BIT] &&
        new_word[cfg_word_pkg::DATA_PROT_BIT];
      nxt_state.prog_erase = !state_ff.nv[cfg_word_pkg::PROG_PROT_BIT] &&
        new_word[cfg_word_pkg::PROG_PROT_BIT];
    end

    // Read path
    nxt_state.rdata = access_ok ? state_ff.nv : '0;

    // Decoded outputs follow the word only while in reset
    if (core_reset)
    begin
      nxt_state.cfg = decode_word(state_ff.nv);
    end

    // Reset and sleep sequencer
    unique case (state_ff.seq)
      cfg_word_pkg::SEQ_PWRUP:
      begin
        if (state_ff.cnt == '0)
        begin
          nxt_state.seq = cfg_word_pkg::SEQ_OSC_WAIT;
        end
        else
        begin
          nxt_state.cnt = state_ff.cnt - cfg_word_pkg::CNT_W'(1);
        end
      end
      cfg_word_pkg::SEQ_BROWN:
      begin
        if (state_ff.cnt == '0)
        begin
          nxt_state.seq = cfg_word_pkg::SEQ_OSC_WAIT;
        end
        else
        begin
          nxt_state.cnt = state_ff.cnt - cfg_word_pkg::CNT_W'(1);
        end
      end
      cfg_word_pkg::SEQ_OSC_WAIT:
      begin
        if (!state_ff.cfg.crystal_mode || state_ff.sync2.xtal_ready)
        begin
          nxt_state.seq = cfg_word_pkg::SEQ_RUN;
        end
      end
      cfg_word_pkg::SEQ_RUN:
      begin
        if (SLEEP_REQ)
        begin
          nxt_state.seq = cfg_word_pkg::SEQ_SLEEP;
        end
      end
      cfg_word_pkg::SEQ_SLEEP:
      begin
        if (watchdog_event || state_ff.sync2.int_req)
        begin
          nxt_state.seq = cfg_word_pkg::SEQ_RUN;
          nxt_state.wake = 1'b1;
        end
      end
      default:
      begin
        nxt_state.seq = cfg_word_pkg::SEQ_OSC_WAIT;
      end
    endcase

    // Brown-out restarts the full delay, independent of the power-up bit
    if (brownout_active)
    begin
      nxt_state.seq = cfg_word_pkg::SEQ_BROWN;
      nxt_state.cnt = CNT_LOAD;
    end
    else if (ext_reset_active)
    begin
      nxt_state.seq = cfg_word_pkg::SEQ_OSC_WAIT;
      nxt_state.wake = (state_ff.seq == cfg_word_pkg::SEQ_SLEEP);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_ff <= STATE_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Outputs
  assign PROG_RDATA = state_ff.rdata;
  assign DATA_ERASE = state_ff.data_erase;
  assign PROG_ERASE = state_ff.prog_erase;
  assign CFG = state_ff.cfg;
  assign CORE_RESET = core_reset;
  assign ASLEEP = (state_ff.seq == cfg_word_pkg::SEQ_SLEEP);
  assign WAKE = state_ff.wake;

  // Oscillator stopped by external reset in internal clock modes
  assign OSC_RUN = !(ext_reset_active && state_ff.cfg.internal_clock);

  // Clock pin carries the clock over four in divided-output modes
  assign DIVIDED_CLOCK_OUTPUT_PIN = state_ff.cfg.divided_clock_output &&
    state_ff.div[cfg_word_pkg::DIV_MSB];
  assign DIVIDED_CLOCK_OUTPUT_OE = state_ff.cfg.divided_clock_output;

endmodule : device_config_word_decoder

//--- tb/cfg_word_checker.sv
/*
  Port assertions for the configuration word decoder.
  Assumes one clock CLK and synchronous active-high reset RST.
*/
`timescale 1ns/1ps
module cfg_word_checker #(
  parameter int PWRUP_CYCLES = 20
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Watched ports
  input wire logic PROG_MODE,
  input wire logic [13:0] PROG_RDATA,
  input wire logic DATA_ERASE,
  input wire logic RESET_PIN_N,
  input wire logic BROWNOUT,
  input wire logic INT_REQ,
  input wire cfg_word_pkg::cfg_type CFG,
  input wire logic CORE_RESET,
  input wire logic OSC_RUN,
  input wire logic ASLEEP,
  input wire logic WAKE
);
  logic [31:0] hold_ff;
  logic long_ff;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Length of the current core reset and whether a long hold is owed
  always_ff @(posedge CLK)
  begin
    hold_ff <= (CORE_RESET && !BROWNOUT && !RST) ? hold_ff + 32'h1 : 32'h0;
    long_ff <= (RST && !CFG.powerup_delay_enable_n) || (BROWNOUT && CFG.brownout_detect_enable) ||
      (long_ff && CORE_RESET);
  end
  sequence s_int_held;
    ASLEEP ##0 INT_REQ [*4];
  endsequence
  property p_closed;
    !PROG_MODE [*4] |-> PROG_RDATA == 14'h0;
  endproperty
  a_closed: assert property (p_closed) else $error("word readable outside programming");
  property p_unimpl;
    PROG_RDATA[11:9] == 3'h0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused bits not zero");
  property p_data_erase;
    DATA_ERASE |=> !DATA_ERASE && PROG_RDATA[8];
  endproperty
  a_data_erase: assert property (p_data_erase) else $error("bad data erase pulse");
  property p_brown;
    (BROWNOUT && CFG.brownout_detect_enable) [*3] |=> CORE_RESET;
  endproperty
  a_brown: assert property (p_brown) else $error("brown-out gave no reset");
  property p_long_hold;
    $fell(CORE_RESET) && long_ff |-> hold_ff >= PWRUP_CYCLES;
  endproperty
  a_long_hold: assert property (p_long_hold) else $error("reset hold too short");
  property p_osc_stop;
    (CFG.internal_clock && CFG.ext_reset_pin_select && !RESET_PIN_N) [*3] |-> !OSC_RUN;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator kept running");
  property p_hold_cfg;
    !$past(CORE_RESET) |-> $stable(CFG);
  endproperty
  a_hold_cfg: assert property (p_hold_cfg) else $error("config moved in run");
  property p_wake;
    s_int_held |=> !ASLEEP;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on interrupt");
endmodule : cfg_word_checker
bind device_config_word_decoder cfg_word_checker #(.PWRUP_CYCLES(PWRUP_CYCLES)) chk_u (
  .CLK(CLK), .RST(RST), .PROG_MODE(PROG_MODE), .PROG_RDATA(PROG_RDATA), .DATA_ERASE(DATA_ERASE),
  .RESET_PIN_N(RESET_PIN_N), .BROWNOUT(BROWNOUT), .INT_REQ(INT_REQ), .CFG(CFG), .CORE_RESET(CORE_RESET),
  .OSC_RUN(OSC_RUN), .ASLEEP(ASLEEP), .WAKE(WAKE)
);

//--- tb/cfg_programmer.sv
/*
  Programmer model for the configuration word port.
  Assumes its tasks are called just after a falling clock edge.
*/
`timescale 1ns/1ps
module cfg_programmer (
  // Clock
  input wire logic clk,
  // Programming lines
  input wire logic [13:0] rdata,
  output logic mode,
  output logic wr,
  output logic [13:0] addr,
  output logic [13:0] wdata
);
  initial
  begin
    {mode, wr} = 2'h0;
    {addr, wdata} = 28'h0;
  end
  task automatic put(input logic [13:0] a, input logic [13:0] d);
    mode = 1'b1;
    addr = a;
    repeat (4) @(negedge clk);
    wdata = {rdata[13:12], d[11:0]};
    wr = 1'b1;
    repeat (4) @(negedge clk);
    wr = 1'b0;
    repeat (4) @(negedge clk);
    wdata = ~wdata;
  endtask : put
  task automatic leave();
    mode = 1'b0;
    addr = ~addr;
    repeat (4) @(negedge clk);
  endtask : leave
endmodule : cfg_programmer

//--- tb/tb.sv
/*
  Self-checking bench for the configuration word decoder.
  Assumes a 25 MHz clock with inputs driven at the falling edge.
*/
`timescale 1ns/1ps
module tb;
  logic clk, rst, pin_n, brown, xrdy, wdt, irq, slp, pm, pw, de, pe, cr, osc, asl, wk, ck, coe, a;
  logic [13:0] pa, pd, rd, last;
  cfg_word_pkg::cfg_type cfg;
  int num_errors, checked, n_de, n_pe, n_wk, n;
  cfg_programmer prog_u (.clk(clk), .rdata(rd), .mode(pm), .wr(pw), .addr(pa), .wdata(pd));
  device_config_word_decoder #(.PWRUP_CYCLES(20), .BLANK_WORD(14'h31ef)) dut_u (
    .CLK(clk), .RST(rst), .PROG_MODE(pm), .PROG_WRITE(pw), .PROG_ADDR(pa), .PROG_WDATA(pd),
    .PROG_RDATA(rd), .DATA_ERASE(de), .PROG_ERASE(pe), .RESET_PIN_N(pin_n), .BROWNOUT(brown),
    .XTAL_READY(xrdy), .WATCHDOG_TIMEOUT(wdt), .INT_REQ(irq), .SLEEP_REQ(slp), .CFG(cfg),
    .CORE_RESET(cr), .OSC_RUN(osc), .ASLEEP(asl), .WAKE(wk), .DIVIDED_CLOCK_OUTPUT_PIN(ck), .DIVIDED_CLOCK_OUTPUT_OE(coe)
  );
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    n_de += (de === 1'b1);
    n_pe += (pe === 1'b1);
    n_wk += (wk === 1'b1);
  end
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic await(input logic v);
    for (int i = 0; i < 60 && cr !== v; i++)
      @(negedge clk);
    chk("core reset", v, cr);
  endtask : await
  task automatic wr(input logic [13:0] w);
    int d;
    int p;
    logic [2:0] c;
    d = n_de;
    p = n_pe;
    c = w[2:0];
    prog_u.put(14'h2007, w);
    chk("word", {2'h3, 3'h0, w[8:0]}, rd);
    chk("config", {2'h3, w[8:0], c[2] & c[0], (c == 3'h3 || c == 3'h4 || c == 3'h6), (c[2:1] == 2'b10),
      (c < 3'h3), c[2], !w[5]}, cfg);
    chk("clock out enable", c[2] & c[0], coe);
    chk("data erase", w[8] & !last[8], n_de - d);
    chk("program erase", w[7] & !last[7], n_pe - p);
    last = w;
  endtask : wr
  task automatic go(input logic [13:0] w);
    wr(w);
    prog_u.leave();
    await(1'b0);
  endtask : go
  task automatic t_brown(input logic en);
    go({5'h0, 2'h3, en, 3'h7, 3'h4});
    brown = 1'b1;
    repeat (3) @(negedge clk);
    brown = 1'b0;
    repeat (2) @(negedge clk);
    for (n = 0; n < 100 && cr === 1'b1; n++)
      @(negedge clk);
    chk("brown-out hold", en, n >= 20);
    await(1'b0);
    $display("brown-out test done");
  endtask : t_brown
  task automatic t_ext(input logic sel);
    go({5'h0, 2'h3, 1'b0, sel, 2'h1, 3'h4});
    pin_n = 1'b0;
    repeat (4) @(negedge clk);
    chk("external reset", {sel, !sel}, {cr, osc});
    pin_n = 1'b1;
    for (n = 0; n < 60 && cr === 1'b1; n++)
      @(negedge clk);
    chk("delay after external reset", 1'b1, n <= 4);
    await(1'b0);
    $display("external reset test done");
  endtask : t_ext
  task automatic t_xtal();
    go({5'h0, 2'h3, 1'b0, 1'b1, 2'h3, 3'h1});
    xrdy = 1'b0;
    pin_n = 1'b0;
    repeat (4) @(negedge clk);
    chk("crystal oscillator run", 1'b1, osc);
    pin_n = 1'b1;
    repeat (10) @(negedge clk);
    chk("start-up wait", 1'b1, cr);
    xrdy = 1'b1;
    await(1'b0);
    $display("crystal start-up test done");
  endtask : t_xtal
  task automatic t_sleep(input logic by_dog);
    int w0;
    w0 = n_wk;
    slp = 1'b1;
    @(negedge clk);
    slp = 1'b0;
    @(negedge clk);
    chk("asleep", 1'b1, asl);
    {irq, wdt} = {!by_dog, by_dog};
    repeat (6) @(negedge clk);
    {irq, wdt} = 2'h0;
    repeat (3) @(negedge clk);
    chk("woken", 2'h1, {asl, n_wk - w0 == 1});
    $display("sleep test done");
  endtask : t_sleep
  initial
  begin
    repeat (5000) @(negedge clk);
    num_errors++;
    end_sim();
  end
  initial
  begin
    {rst, pin_n, xrdy} = 3'h7;
    {brown, wdt, irq, slp} = 4'h0;
    last = 14'h31ef;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk("blank config", 17'h1fbe2, cfg);
    chk("closed read", 14'h0, rd);
    for (n = 0; n < 100 && cr === 1'b1; n++)
      @(negedge clk);
    chk("power-up hold", 1'b1, n >= 20 && n <= 23);
    a = ck;
    repeat (2) @(negedge clk);
    chk("divided clock", !a, ck);
    $display("power-up test done");
    wr(14'h0eaa);
    wr(14'h0f55);
    wr(14'h01f8);
    for (int c = 0; c < 8; c++)
      wr(14'h01f8 | 14'(c));
    prog_u.put(14'h2006, 14'h0000);
    chk("unmapped read", 14'h0, rd);
    chk("unmapped write", last[8:0], cfg[14:6]);
    $display("word test done");
    t_brown(1'b0);
    t_brown(1'b1);
    t_ext(1'b1);
    t_ext(1'b0);
    t_xtal();
    t_sleep(1'b0);
    t_sleep(1'b1);
    end_sim();
  end
endmodule : tb
